// ---- verilog/asc_top.sv ----
// Sequencing and control logic of a successive-approximation converter with APB registers.
`default_nettype none

// Summary of operation
// - Setting converter_on enables the converter; software sets it last.
// - Interrupt flag with DMA source selected issues one DMA request.
// - increment_rate sets how many conversions pass before the pointer advances.
// - Order mode writes every request at the operation count, which then equals increment_rate.
// - Scatter/gather address comes from input index and buffer size per input.
// - Twelve-bit mode has one sample/hold, never samples channels together.
// - simultaneous_sample reads zero and has no effect in twelve-bit mode.
// - Simultaneous mode samples channels 0-3 or 0-1, else one after another.
// - Unsigned and signed formats; signed fills upper bits with inverted MSB.
// - Auto start begins sampling right after a conversion ends.
// - Without auto start, sampling begins when software sets sample_active.
// - Manual trigger: writing sample_active zero ends sampling and converts.
// - Other triggers clear sample_active in hardware and start conversion.
// - Done sets when conversion completes, clears when a new one starts.
// - Software clears done by writing zero; ones ignored; sequencing undisturbed.
// - twelve_bit_select picks ten bits with four paths or twelve with one.
module asc_top
  import asc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_in,
  input wire logic [11:0] adc_raw,
  output logic [3:0] sh_sample,
  output logic irq,
  output logic dma_req,
  output asc_dma_s dma_out
);

  asc_con1_s con1;
  asc_con2_s con2;
  asc_state_e state;
  logic [2:0] buf_len_sel;
  logic dma_sel;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic done_flag;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [1:0] trig_sync;
  logic trig_prev;
  logic [11:0] raw_meta;
  logic [11:0] raw_sync;
  logic [7:0] tmr;
  logic [7:0] conv_cyc;
  logic [1:0] ch_idx;
  logic [1:0] conv_ch;
  logic [1:0] nch_m1;
  logic [3:0] op_cnt;
  logic [6:0] blk_ptr;
  logic [6:0] len_mask;
  logic [DMA_ADDR_W-1:0] sg_addr;
  logic [15:0] con1_rd;
  logic apb_wr;
  logic wr_con1;
  logic simultaneous_sample_eff;
  logic multi;
  logic trig_fire;
  logic sw_start;
  logic sw_end;
  logic hw_end;
  logic start_conv;
  logic conv_tick;
  logic seq_end;
  logic next_conv;
  logic enter_sample;
  logic irq_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and trigger edge detection.

  // Trigger pin and raw result pass two flops before any logic reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sync <= 2'h0;
      trig_prev <= 1'b0;
      raw_meta <= 12'h000;
      raw_sync <= 12'h000;
    end else begin
      trig_sync <= {trig_sync[0], trig_in};
      trig_prev <= trig_sync[1];
      raw_meta <= adc_raw;
      raw_sync <= raw_meta;
    end
  end

  assign trig_fire = trig_sync[1] & ~trig_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of configuration and sequencing events.

  // The twelve-bit mode has a single path, so channel count and simultaneity collapse.
  assign simultaneous_sample_eff = con1.simultaneous_sample & ~con1.twelve_bit_select;
  assign nch_m1 = con1.twelve_bit_select ? 2'h0 :
                  con2.sh_channel_count[1] ? 2'h3 : {1'b0, con2.sh_channel_count[0]};
  assign multi = simultaneous_sample_eff & (nch_m1 != 2'h0);
  assign conv_cyc = con1.twelve_bit_select ? CONV12_CYC : CONV10_CYC;

  // Start and end of sampling, from software or from hardware.
  assign apb_wr = psel & penable & pready & pwrite;
  assign wr_con1 = apb_wr & (paddr == OFS_CON1);
  assign sw_start = wr_con1 & pwdata[1] & ~con1.auto_sample_start & con1.converter_on & (state == ST_IDLE);
  assign sw_end = wr_con1 & ~pwdata[1] & (con1.conversion_trigger_select == TRIG_MANUAL)
                  & (state == ST_SAMPLE);
  assign hw_end = (state == ST_SAMPLE) & (con1.conversion_trigger_select != TRIG_MANUAL)
                  & ((con1.conversion_trigger_select == TRIG_AUTO) ? (tmr == 8'h00) : trig_fire);
  assign start_conv = con1.converter_on & (sw_end | hw_end);
  assign conv_tick = (state == ST_CONVERT) & (tmr == 8'h00);
  assign seq_end = conv_tick & (~multi | (conv_ch == nch_m1));
  assign next_conv = conv_tick & ~seq_end & con1.converter_on;
  assign enter_sample = con1.converter_on & (((state == ST_IDLE) & (con1.auto_sample_start | sw_start))
                        | (seq_end & con1.auto_sample_start));
  assign irq_evt = conv_tick & (op_cnt == con2.increment_rate);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Idle, sampling and converting; a cleared enable forces idle at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (!con1.converter_on) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (enter_sample) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (start_conv) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (seq_end) begin
            state <= con1.auto_sample_start ? ST_SAMPLE : ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Sample and conversion timer, loaded at each phase start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr <= 8'h00;
    end else if (enter_sample) begin
      tmr <= SAMPLE_CYC - 8'h01;
    end else if (start_conv | next_conv) begin
      tmr <= conv_cyc - 8'h01;
    end else if (tmr != 8'h00) begin
      tmr <= tmr - 8'h01;
    end
  end

  // Channel being converted and channel to sample next in sequential mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ch <= 2'h0;
      ch_idx <= 2'h0;
    end else if (!con1.converter_on) begin
      conv_ch <= 2'h0;
      ch_idx <= 2'h0;
    end else begin
      if (start_conv) begin
        conv_ch <= multi ? 2'h0 : ch_idx;
      end else if (next_conv) begin
        conv_ch <= conv_ch + 2'h1;
      end
      if (multi) begin
        ch_idx <= 2'h0;
      end else if (seq_end) begin
        ch_idx <= (ch_idx == nch_m1) ? 2'h0 : ch_idx + 2'h1;
      end
    end
  end

  // Sample/hold enables: all chosen paths together, or one path at a time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_sample <= 4'h0;
    end else if (state != ST_SAMPLE) begin
      sh_sample <= 4'h0;
    end else if (multi) begin
      sh_sample <= {{2{nch_m1[1]}}, |nch_m1, 1'b1};
    end else begin
      sh_sample <= 4'h1 << ch_idx;
    end
  end

  // Done flag: set by completion, cleared at a new start or by a software zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else if (seq_end) begin
      done_flag <= 1'b1;
    end else if (start_conv) begin
      done_flag <= 1'b0;
    end else if (wr_con1 & ~pwdata[0]) begin
      done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and DMA addressing.

  // Format the converted word as unsigned, or signed with the inverted top bit.
  always_comb begin
    if (con1.twelve_bit_select) begin
      if (con1.result_format == RESULT_FORMAT_SIGNED) begin
        next_result = {{5{~raw_sync[11]}}, raw_sync[10:0]};
      end else begin
        next_result = {4'h0, raw_sync};
      end
    end else begin
      if (con1.result_format == RESULT_FORMAT_SIGNED) begin
        next_result = {{7{~raw_sync[9]}}, raw_sync[8:0]};
      end else begin
        next_result = {6'h00, raw_sync[9:0]};
      end
    end
  end

  // Scatter/gather address: input index times words per input plus the pointer.
  assign len_mask = 7'h7F >> (3'h7 - buf_len_sel);
  assign sg_addr = (DMA_ADDR_W'(conv_ch) << buf_len_sel) | DMA_ADDR_W'(blk_ptr);

  // Operation counter steps at every conversion; buffer pointer advances every increment_rate+1 conversions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt <= 4'h0;
      blk_ptr <= 7'h00;
      result <= 16'h0000;
    end else if (!con1.converter_on) begin
      op_cnt <= 4'h0;
      blk_ptr <= 7'h00;
    end else if (conv_tick) begin
      result <= next_result;
      op_cnt <= irq_evt ? 4'h0 : op_cnt + 4'h1;
      if (irq_evt) begin
        blk_ptr <= (blk_ptr + 7'h01) & len_mask;
      end
    end
  end

  // One DMA request per interrupt flag event when the DMA source is selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= 1'b0;
      dma_out <= '0;
    end else begin
      dma_req <= irq_evt & dma_sel;
      if (irq_evt) begin
        dma_out.addr <= con1.dma_order_mode ? DMA_ADDR_W'(op_cnt) : sg_addr;
        dma_out.data <= next_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  // Sticky bits, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((apb_wr & (paddr == OFS_IRQ_STAT)) ? pwdata[1:0] : 2'h0))
                  | {irq_evt, seq_end};
      if (apb_wr & (paddr == OFS_IRQ_MASK)) begin
        irq_mask <= pwdata[1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file.

  // Configuration writes; sample_active and done are handled by the sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con1 <= asc_con1_s'(CON_RESET);
      con2 <= asc_con2_s'(CON_RESET);
      buf_len_sel <= 3'h0;
      dma_sel <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == OFS_CON1) begin
        con1 <= asc_con1_s'(pwdata[15:0] & CON1_CFG_MASK);
      end
      if (paddr == OFS_CON2) begin
        con2 <= asc_con2_s'(pwdata[15:0] & CON2_CFG_MASK);
      end
      if (paddr == OFS_DMACFG) begin
        buf_len_sel <= pwdata[DMACFG_LEN_LSB+:3];
        dma_sel <= pwdata[DMACFG_SEL_BIT];
      end
    end
  end

  assign con1_rd = {con1[15:4], simultaneous_sample_eff, con1.auto_sample_start, state == ST_SAMPLE, done_flag};

  // Read data and error are captured in the setup cycle; ready follows it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr <= 1'b0;
        case (paddr)
          OFS_CON1: prdata <= {16'h0000, con1_rd};
          OFS_CON2: prdata <= {16'h0000, con2};
          OFS_DMACFG: prdata <= {23'h0, dma_sel, 5'h00, buf_len_sel};
          OFS_RESULT: prdata <= {16'h0000, result};
          OFS_IRQ_STAT: prdata <= {30'h0, irq_stat};
          OFS_IRQ_MASK: prdata <= {30'h0, irq_mask};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_manual_end;
    (state == ST_SAMPLE) && con1.converter_on && sw_end;
  endsequence

  sequence s_in_convert;
    (state == ST_CONVERT) ##1 (state == ST_CONVERT || seq_end || !con1.converter_on);
  endsequence

  a_off_holds_idle: assert property (!con1.converter_on |=> state == ST_IDLE)
    else $error("sequencer left idle while converter off");
  a_manual_end_conv: assert property (s_manual_end |=> s_in_convert)
    else $error("software end of sampling did not start conversion");
  a_trig_end_conv: assert property (hw_end && con1.converter_on |=> state == ST_CONVERT && !con1_rd[1])
    else $error("trigger did not end sampling");
  a_done_on_end: assert property (seq_end |=> done_flag && irq_stat[IRQ_DONE_BIT])
    else $error("done not set at conversion end");
  a_done_clr_start: assert property (start_conv |=> !done_flag)
    else $error("done not cleared at conversion start");
  a_done_w1_ignored: assert property (wr_con1 && pwdata[0] && !done_flag && !seq_end |=> !done_flag)
    else $error("software set the done flag");
  a_auto_restart: assert property (seq_end && con1.auto_sample_start && con1.converter_on
                                   |=> state == ST_SAMPLE ##1 sh_sample != 4'h0)
    else $error("auto start did not resume sampling");
  a_single_sh_12b: assert property (con1.twelve_bit_select ##1 con1.twelve_bit_select
                                    |-> $onehot0(sh_sample) && !simultaneous_sample_eff)
    else $error("several paths sampled in twelve-bit mode");
  a_dma_on_flag: assert property (irq_evt && dma_sel |=> dma_req ##1 !dma_req)
    else $error("DMA request not a single pulse on flag");
  a_order_addr: assert property (irq_evt && dma_sel && con1.dma_order_mode
                                 |=> dma_out.addr == DMA_ADDR_W'($past(con2.increment_rate)))
    else $error("order mode address wrong");

endmodule
`default_nettype wire

// ---- verilog/asc_pkg.sv ----
// Package with register map, field layouts, states and timing for the converter sequencer.
`default_nettype none
package asc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CON1 = 8'h00;
  localparam logic [7:0] OFS_CON2 = 8'h04;
  localparam logic [7:0] OFS_DMACFG = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Writable bits of the two control registers and their value after reset.
  localparam logic [15:0] CON1_CFG_MASK = 16'hB7EC;
  localparam logic [15:0] CON2_CFG_MASK = 16'hE73F;
  localparam logic [15:0] CON_RESET = 16'h0000;
  // Field positions in the extra DMA configuration register.
  localparam int DMACFG_LEN_LSB = 0;
  localparam int DMACFG_SEL_BIT = 8;
  // Interrupt status and mask bit positions.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  // Result format and trigger source codes.
  localparam logic [1:0] RESULT_FORMAT_SIGNED = 2'h1;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // Timing: figures in ns, cycle counts derived from the 40 MHz clock.
  localparam int CLK_MHZ = 40;
  localparam int SAMPLE_TIME_NS = 100;
  localparam int CONV10_TIME_NS = 1000;
  localparam int CONV12_TIME_NS = 2000;
  localparam logic [7:0] SAMPLE_CYC = 8'((SAMPLE_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CONV10_CYC = 8'((CONV10_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CONV12_CYC = 8'((CONV12_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam int DMA_ADDR_W = 11;

  // Control register one layout.
  typedef struct packed {
    logic converter_on;
    logic rsv14;
    logic idle_stop;
    logic dma_order_mode;
    logic rsv11;
    logic twelve_bit_select;
    logic [1:0] result_format;
    logic [2:0] conversion_trigger_select;
    logic rsv4;
    logic simultaneous_sample;
    logic auto_sample_start;
    logic sample_active;
    logic done;
  } asc_con1_s;

  // Control register two layout.
  typedef struct packed {
    logic [2:0] reference_config;
    logic [1:0] rsv12;
    logic scan_inputs;
    logic [1:0] sh_channel_count;
    logic fill_half_status;
    logic rsv6;
    logic [3:0] increment_rate;
    logic fill_mode;
    logic alternate_input_select;
  } asc_con2_s;

  // Word handed to the DMA channel with each request.
  typedef struct packed {
    logic [DMA_ADDR_W-1:0] addr;
    logic [15:0] data;
  } asc_dma_s;

  // Sequencer states, Gray coded along idle, sample, convert.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3
  } asc_state_e;
endpackage
`default_nettype wire

// ---- tb/asc_dma_sink.sv ----
// Model of the DMA channel and interrupt logic that stand beyond the sequencer.
`default_nettype none
module asc_dma_sink
  import asc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_req,
  input wire asc_dma_s dma_out,
  input wire logic irq
);
  int req_count;
  int irq_entries;
  logic irq_seen;
  logic [DMA_ADDR_W-1:0] addr_q[$];
  logic [15:0] data_q[$];
  //////////////////////////////////////////////////////////////////////////////
  // Each request pulse moves one word, at the address the converter offers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_count <= 0;
      addr_q.delete();
      data_q.delete();
    end else if (dma_req === 1'b1) begin
      req_count <= req_count + 1;
      addr_q.push_back(dma_out.addr);
      data_q.push_back(dma_out.data);
    end
  end
  // The processor enters its handler once for each rise of the level request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_entries <= 0;
      irq_seen <= 1'b0;
    end else begin
      irq_seen <= irq;
      if (irq === 1'b1 && irq_seen !== 1'b1) irq_entries <= irq_entries + 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/asc_top_test.sv ----
// Self-checking bench for the converter sequencer with its register bus.
`default_nettype none
module asc_top_test
  import asc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig_in = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [11:0] adc_raw = 0;
  logic pready, pslverr, irq, dma_req, serr;
  logic [3:0] sh_sample;
  logic [15:0] c;
  asc_dma_s dma_out;
  int err_count = 0, total_checks = 0, seed = 32'h359e, i;
  int exp_a[4] = '{0, 1, 0, 0};
  //////////////////////////////////////////////////////////////////////////////
  // Clock, design and far-side model.
  always #12.5 pclk = ~pclk;
  asc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .adc_raw(adc_raw), .sh_sample(sh_sample), .irq(irq), .dma_req(dma_req),
    .dma_out(dma_out));
  asc_dma_sink sink (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .dma_out(dma_out), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One bus transfer; the request is held until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(0, 1);
      wrap_up;
    end
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 0);
    chk(r, e);
  endtask
  // Polls the done flag under a bounded count.
  task wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CON1, 0);
      n++;
    end while (r[0] !== 1'b1 && n < 200);
    if (r[0] !== 1'b1) begin
      chk(0, 1);
      wrap_up;
    end
  endtask
  // One conversion started and ended by software; the enable is set before the start request.
  task conv(input logic [15:0] k);
    wr(OFS_CON1, k | 16'h8000);
    wr(OFS_CON1, k | 16'h8002);
    wr(OFS_CON1, k | 16'h8000);
    wait_done;
  endtask
  // Expected result word for a raw code, format and width.
  function automatic logic [15:0] fmt(input logic [11:0] d, input logic [1:0] f, input logic t);
    if (f != RESULT_FORMAT_SIGNED) return t ? {4'h0, d} : {6'h00, d[9:0]};
    return t ? {{5{~d[11]}}, d[10:0]} : {{7{~d[9]}}, d[8:0]};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Hang guard.
  initial begin
    repeat (100000) @(posedge pclk);
    chk(0, 1);
    wrap_up;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CON1, CON_RESET);
    rd(OFS_CON2, CON_RESET);
    apb(1'b0, 8'h40, 0);
    chk(r, 0);
    chk(serr, 1);
    // A start request while switched off leaves the sequencer idle.
    wr(OFS_CON1, 32'h0002);
    repeat (3) @(posedge pclk);
    chk(sh_sample, 0);
    rd(OFS_CON1, 0);
    // Every format code in both widths, each with a fresh random input.
    for (i = 0; i < 8; i++) begin
      c = {5'h00, i[2], i[1:0], 8'h00};
      adc_raw <= 12'($random(seed));
      wr(OFS_CON1, c);
      wr(OFS_CON1, c | 16'h8000);
      wr(OFS_CON1, c | 16'h8002);
      rd(OFS_CON1, c | 16'h8002);
      chk(sh_sample, 1);
      wr(OFS_CON1, c | 16'h8000);
      wait_done;
      rd(OFS_RESULT, fmt(adc_raw, c[9:8], c[10]));
    end
    // Ones written to done are ignored, a zero clears it.
    wr(OFS_CON1, c | 16'h8001);
    rd(OFS_CON1, c | 16'h8001);
    wr(OFS_CON1, c | 16'h8000);
    rd(OFS_CON1, c | 16'h8000);
    wr(OFS_CON1, c | 16'h8001);
    rd(OFS_CON1, c | 16'h8000);
    // Sticky status, mask and level output.
    rd(OFS_IRQ_STAT, 3);
    chk(irq, 0);
    wr(OFS_IRQ_MASK, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    wr(OFS_IRQ_STAT, 3);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    rd(OFS_IRQ_STAT, 0);
    // Four and two paths together, then one path in twelve-bit mode.
    for (i = 0; i < 3; i++) begin
      c = (i == 2) ? 16'h0408 : 16'h0008;
      wr(OFS_CON1, 0);
      wr(OFS_CON2, (i == 1) ? 32'h0100 : 32'h0200);
      wr(OFS_CON1, c | 16'h8000);
      wr(OFS_CON1, c | 16'h8002);
      rd(OFS_CON1, (i == 2) ? 32'h8402 : 32'h800A);
      chk(sh_sample, (i == 0) ? 4'hF : (i == 1) ? 4'h3 : 4'h1);
      wr(OFS_CON1, c | 16'h8000);
      wait_done;
    end
    // Auto start with the internal counter: done returns with no software start.
    wr(OFS_CON1, 0);
    wr(OFS_CON2, 0);
    wr(OFS_CON1, 32'h80E4);
    wait_done;
    wr(OFS_CON1, 32'h80E4);
    wait_done;
    wr(OFS_CON1, 0);
    // A second write clears a done flag that a conversion ending at switch-off may have set.
    wr(OFS_CON1, 0);
    chk(sh_sample, 0);
    rd(OFS_CON1, 0);
    // External trigger: sampling lasts until its rising edge.
    wr(OFS_CON1, 32'h8040);
    wr(OFS_CON1, 32'h8042);
    repeat (10) @(posedge pclk);
    rd(OFS_CON1, 32'h8042);
    trig_in <= 1'b1;
    repeat (4) @(posedge pclk);
    trig_in <= 1'b0;
    wait_done;
    // DMA: two conversions per request with scatter addresses, then order mode.
    wr(OFS_CON1, 0);
    wr(OFS_DMACFG, 32'h0101);
    wr(OFS_CON2, 32'h0004);
    for (i = 0; i < 4; i++) conv(16'h0000);
    wr(OFS_CON1, 0);
    wr(OFS_CON2, 0);
    for (i = 0; i < 2; i++) conv(16'h1000);
    repeat (3) @(posedge pclk);
    chk(sink.req_count, 4);
    for (i = 0; i < 4; i++) begin
      chk(sink.addr_q[i], exp_a[i]);
      chk(sink.data_q[i], fmt(adc_raw, 2'h0, 1'b0));
    end
    chk(sink.irq_entries, 2);
    wrap_up;
  end
endmodule
`default_nettype wire
